// ==== logic/input_filter_change_interrupt.sv ====
// Filtered sixteen line input port with change interrupt and a slave.
`timescale 1ns/1ps
module input_filter_change_interrupt #(
  parameter int LINES = input_filter_pkg::LINES,
  parameter int BASE_DIV = input_filter_pkg::BASE_DIV
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [input_filter_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Input pins, active low.
  input wire logic [LINES-1:0] pin_n_i,
  // Interrupt request.
  output logic irq_o
);
  initial begin
    if (LINES < 1 || LINES > 16) $error("LINES must be 1 to 16.");
    if (BASE_DIV < 1) $error("BASE_DIV must be at least 1.");
  end

  input_filter_pkg::wb_req_type req;
  logic [LINES-1:0] sync1_reg;
  logic [LINES-1:0] sync2_reg;
  logic [LINES-1:0] filt;
  logic [LINES-1:0] prev_reg;
  logic [LINES-1:0] mask_reg;
  logic [LINES-1:0] edge_reg;
  logic [LINES-1:0] status_reg;
  logic [LINES-1:0] hit;
  logic [input_filter_pkg::FLEN_W-1:0] flen_reg;
  logic [input_filter_pkg::TICK_W-1:0] need;
  logic [$clog2(BASE_DIV+1)-1:0] div_reg;
  logic tick_reg;
  logic take;
  logic rd_status;

  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i,
                 sel: wb_sel_i, adr: wb_adr_i, dat: wb_dat_i};
  assign take = req.cyc && req.stb && !wb_ack_o;
  assign rd_status = take && !req.we &&
                     req.adr == input_filter_pkg::OFS_STATUS;

  // Input synchroniser with inversion of the active low pins.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= ~pin_n_i;
      sync2_reg <= sync1_reg;
    end
  end

  // Divider that makes the 8 MHz base tick.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_reg <= '0;
      tick_reg <= 1'b0;
    end else if (div_reg == ($clog2(BASE_DIV+1))'(BASE_DIV - 1)) begin
      div_reg <= '0;
      tick_reg <= 1'b1;
    end else begin
      div_reg <= div_reg + 1'b1;
      tick_reg <= 1'b0;
    end
  end

  assign need = input_filter_pkg::TICK_ONE << flen_reg;

  genvar g;
  generate
    for (g = 0; g < LINES; g++) begin : gen_line
      glitch_filter #(
        .TICK_W(input_filter_pkg::TICK_W)
      ) u_filter (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(tick_reg),
        .bypass_i(flen_reg == '0),
        .need_i(need),
        .din_i(sync2_reg[g]),
        .dout_o(filt[g])
      );
      // Edge select picks rise or fall of the logical value.
      assign hit[g] = !mask_reg[g] && (edge_reg[g] ?
                      (prev_reg[g] && !filt[g]) :
                      (!prev_reg[g] && filt[g]));
    end
  endgenerate

  // Previous filtered value for edge detection.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_reg <= '0;
    end else begin
      prev_reg <= filt;
    end
  end

  // Configuration registers written over the bus.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flen_reg <= input_filter_pkg::FLEN_RESET;
      mask_reg <= input_filter_pkg::MASK_RESET[LINES-1:0];
      edge_reg <= input_filter_pkg::EDGE_RESET[LINES-1:0];
    end else if (take && req.we) begin
      case (req.adr)
        input_filter_pkg::OFS_FILTER: begin
          if (req.sel[0] &&
              req.dat[input_filter_pkg::FLEN_W-1:0] <=
              input_filter_pkg::FLEN_MAX) begin
            flen_reg <= req.dat[input_filter_pkg::FLEN_W-1:0];
          end
        end
        input_filter_pkg::OFS_MASK: begin
          for (int i = 0; i < LINES; i++) begin
            if (req.sel[i/8]) begin
              mask_reg[i] <= req.dat[i];
            end
          end
        end
        input_filter_pkg::OFS_EDGE: begin
          for (int i = 0; i < LINES; i++) begin
            if (req.sel[i/8]) begin
              edge_reg[i] <= req.dat[i];
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Status bits: new events win over the clearing read.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_reg <= input_filter_pkg::STATUS_RESET[LINES-1:0];
    end else if (rd_status) begin
      status_reg <= hit;
    end else begin
      status_reg <= status_reg | hit;
    end
  end

  // Interrupt request follows the status bits.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else if (rd_status) begin
      irq_o <= |hit;
    end else begin
      irq_o <= |(status_reg | hit);
    end
  end

  // Bus answer one cycle after the request.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= take;
      wb_dat_o <= '0;
      if (take && !req.we) begin
        case (req.adr)
          input_filter_pkg::OFS_STATUS:
            wb_dat_o <= {{(32-2*LINES){1'b0}}, filt, status_reg};
          input_filter_pkg::OFS_FILTER:
            wb_dat_o <= {{(32-input_filter_pkg::FLEN_W){1'b0}}, flen_reg};
          input_filter_pkg::OFS_MASK:
            wb_dat_o <= {{(32-LINES){1'b0}}, mask_reg};
          input_filter_pkg::OFS_EDGE:
            wb_dat_o <= {{(32-LINES){1'b0}}, edge_reg};
          default:
            wb_dat_o <= '0;
        endcase
      end
    end
  end

  // Check model of line zero: ticks counted since its input last moved.
  logic chk_last_reg;
  logic [input_filter_pkg::TICK_W-1:0] chk_run_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chk_last_reg <= 1'b0;
      chk_run_reg <= '0;
    end else begin
      chk_last_reg <= sync2_reg[0];
      if (sync2_reg[0] != chk_last_reg) begin
        chk_run_reg <= {{(input_filter_pkg::TICK_W-1){1'b0}}, tick_reg};
      end else if (tick_reg && chk_run_reg != '1) begin
        chk_run_reg <= chk_run_reg + 1'b1;
      end
    end
  end

  // Steps of a status read and of a filtered level change.
  sequence s_status_taken;
    rd_status ##1 wb_ack_o;
  endsequence

  sequence s_logic_rise;
    !filt[0] ##1 filt[0];
  endsequence

  sequence s_logic_fall;
    filt[0] ##1 !filt[0];
  endsequence

  a_mask_blocks: assert property (
    @(posedge clk_i) disable iff (rst_i)
    mask_reg[0] && !rd_status && !$past(rd_status) |=>
    status_reg[0] == $past(status_reg[0]))
    else $error("Masked line changed its status.");

  a_irq_follows: assert property (
    @(posedge clk_i) disable iff (rst_i)
    irq_o == (|status_reg))
    else $error("Request differs from status.");

  a_read_clears: assert property (
    @(posedge clk_i) disable iff (rst_i)
    rd_status && hit == '0 |=> status_reg == '0 && !irq_o)
    else $error("Status read did not clear.");

  a_rise_sets: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !mask_reg[0] && !edge_reg[0] && !prev_reg[0] && filt[0] |=>
    status_reg[0])
    else $error("Rising logical edge lost.");

  a_fall_sets: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !mask_reg[0] && edge_reg[0] && prev_reg[0] && !filt[0] |=>
    status_reg[0])
    else $error("Falling logical edge lost.");

  a_bypass_path: assert property (
    @(posedge clk_i) disable iff (rst_i)
    flen_reg == '0 && $past(flen_reg) == '0 |->
    filt == $past(sync2_reg))
    else $error("Bypass did not pass input.");

  a_flen_range: assert property (
    @(posedge clk_i) disable iff (rst_i)
    flen_reg <= input_filter_pkg::FLEN_MAX)
    else $error("Filter length out of range.");

  a_filter_holds: assert property (
    @(posedge clk_i) disable iff (rst_i)
    flen_reg != '0 && $stable(flen_reg) && !tick_reg |=>
    $stable(filt))
    else $error("Filter moved without a tick.");

  a_ack_once: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("Ack held two cycles.");

  a_filter_waits: assert property (
    @(posedge clk_i) disable iff (rst_i)
    flen_reg != '0 && $stable(flen_reg) && $changed(filt[0]) |->
    chk_run_reg >= need)
    else $error("Filter moved before the interval ran out.");

  a_filter_passes: assert property (
    @(posedge clk_i) disable iff (rst_i)
    flen_reg != '0 && $stable(flen_reg) && $changed(chk_run_reg) &&
    chk_run_reg == need |-> filt[0] == chk_last_reg)
    else $error("Filter kept its level after the interval.");

  a_ack_answers: assert property (@(posedge clk_i) disable iff (rst_i)
    take |=> wb_ack_o)
    else $error("Request taken without an answer.");

  a_status_data: assert property (
    @(posedge clk_i) disable iff (rst_i)
    s_status_taken |-> wb_dat_o[LINES-1:0] == $past(status_reg) &&
    wb_dat_o[2*LINES-1:LINES] == $past(filt))
    else $error("Status read returned the wrong word.");

  a_reset_state: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $fell(rst_i) |-> flen_reg == input_filter_pkg::FLEN_RESET &&
    mask_reg == input_filter_pkg::MASK_RESET[LINES-1:0] &&
    edge_reg == input_filter_pkg::EDGE_RESET[LINES-1:0] &&
    status_reg == '0 && !irq_o)
    else $error("State after reset is wrong.");

  a_rise_flags: assert property (
    @(posedge clk_i) disable iff (rst_i)
    s_logic_rise ##0 (!mask_reg[0] && !edge_reg[0]) |=> status_reg[0])
    else $error("Logical rise on an open line not flagged.");

  a_fall_flags: assert property (
    @(posedge clk_i) disable iff (rst_i)
    s_logic_fall ##0 (!mask_reg[0] && edge_reg[0]) |=> status_reg[0])
    else $error("Logical fall on an open line not flagged.");

  a_tick_period: assert property (
    @(posedge clk_i) disable iff (rst_i)
    tick_reg |-> ##BASE_DIV tick_reg)
    else $error("Base tick spacing is wrong.");

  a_write_lands: assert property (
    @(posedge clk_i) disable iff (rst_i)
    take && req.we && req.adr == input_filter_pkg::OFS_MASK &&
    req.sel[1:0] == 2'h3 |=> mask_reg == $past(req.dat[LINES-1:0]))
    else $error("Mask write did not land.");

  a_irq_rises: assert property (
    @(posedge clk_i) disable iff (rst_i)
    hit != '0 |=> irq_o)
    else $error("Flagged line raised no request.");
endmodule

// ==== logic/input_filter_pkg.sv ====
// Package with register map, field layouts and timing constants.
package input_filter_pkg;
  localparam int LINES = 16;
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFS_INPUT = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_FILTER = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_MASK = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_EDGE = 4'hc;
  localparam int FLEN_W = 5;
  localparam logic [FLEN_W-1:0] FLEN_MAX = 5'h14;
  localparam logic [FLEN_W-1:0] FLEN_RESET = 5'h00;
  localparam logic [LINES-1:0] MASK_RESET = 16'hffff;
  localparam logic [LINES-1:0] EDGE_RESET = 16'h0000;
  localparam logic [LINES-1:0] STATUS_RESET = 16'h0000;
  localparam int CLK_MHZ = 250;
  localparam int BASE_MHZ = 8;
  localparam int BASE_DIV = CLK_MHZ / BASE_MHZ;
  localparam int TICK_W = 22;
  localparam logic [TICK_W-1:0] TICK_ONE = 22'h000001;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h0;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [ADDR_W-1:0] adr;
    logic [31:0] dat;
  } wb_req_type;
endpackage

// ==== logic/glitch_filter.sv ====
// One input line filter that needs a stable run of base ticks.
`timescale 1ns/1ps
module glitch_filter #(
  parameter int TICK_W = 22
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Control.
  input wire logic tick_i,
  input wire logic bypass_i,
  input wire logic [TICK_W-1:0] need_i,
  // Data.
  input wire logic din_i,
  output logic dout_o
);
  logic [TICK_W-1:0] run_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_reg <= '0;
      dout_o <= 1'b0;
    end else if (bypass_i) begin
      run_reg <= '0;
      dout_o <= din_i;
    end else if (din_i == dout_o) begin
      run_reg <= '0;
    end else if (tick_i) begin
      if (run_reg + 1'b1 >= need_i) begin
        dout_o <= din_i;
        run_reg <= '0;
      end else begin
        run_reg <= run_reg + 1'b1;
      end
    end
  end
endmodule

// ==== dv/pin_model.sv ====
// Model of the switches that drive the sixteen active low input pins.
`timescale 1ns/1ps
module pin_model (
  // Wanted line states, one means switch closed.
  input wire logic [15:0] act_i,
  // Pins, pulled up while a switch is open.
  output logic [15:0] pin_n_o
);
  // A closed switch pulls its pin low, an open one leaves the pull-up.
  assign pin_n_o = ~act_i;
endmodule

// ==== dv/input_filter_change_interrupt_bench.sv ====
// Self-checking bench for the filtered change interrupt block.
`timescale 1ns/1ps
module input_filter_change_interrupt_bench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] sel = 4'h0;
  logic [3:0] adr = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] dat_o;
  logic ack;
  logic irq;
  logic [15:0] act = 16'h0;
  logic [15:0] pin_n;
  logic [31:0] rd;
  logic [15:0] a;
  logic [15:0] m;
  logic [15:0] e;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc_cnt = 0;

  always #2 clk_i = ~clk_i;

  pin_model u_pins (.act_i(act), .pin_n_o(pin_n));
  input_filter_change_interrupt #(.BASE_DIV(2)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .pin_n_i(pin_n), .irq_o(irq));

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_irq(input logic exp);
    cmp_count++;
    if (irq !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t irq=%h exp=%h", $time, irq, exp);
    end
  endtask

  // One classic Wishbone cycle; read data lands in rd.
  task automatic bus(input logic w, input logic [3:0] ad,
                     input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ad;
    dat <= d;
    sel <= 4'hf;
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic pins(input logic [15:0] v, input int n);
    @(posedge clk_i);
    act <= v;
    repeat (n) @(posedge clk_i);
  endtask

  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 5000) begin
      error_cnt++;
      give_verdict();
    end
  end

  initial begin
    void'($urandom(19068));
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b0, 4'h4, 32'h0);
    check(rd, 32'h0);
    bus(1'b0, 4'h8, 32'h0);
    check(rd, 32'h0000ffff);
    bus(1'b0, 4'hc, 32'h0);
    check(rd, 32'h0);
    bus(1'b0, 4'h0, 32'h0);
    check(rd, 32'h0);
    check_irq(1'b0);
    bus(1'b1, 4'h4, 32'h0b);
    bus(1'b0, 4'h4, 32'h0);
    check(rd, 32'h0b);
    bus(1'b1, 4'h4, 32'h14);
    bus(1'b0, 4'h4, 32'h0);
    check(rd, 32'h14);
    bus(1'b0, 4'h2, 32'h0);
    check(rd, 32'h0);
    bus(1'b1, 4'h4, 32'h0);
    for (int i = 0; i < 6; i++) begin
      a = 16'($urandom);
      m = (i == 0) ? 16'h0 : 16'($urandom);
      e = 16'($urandom);
      bus(1'b1, 4'h8, {16'h0, m});
      bus(1'b1, 4'hc, {16'h0, e});
      pins(a, 10);
      check_irq(|(a & ~e & ~m));
      bus(1'b0, 4'h0, 32'h0);
      check(rd, {a, a & ~e & ~m});
      @(posedge clk_i);
      check_irq(1'b0);
      pins(16'h0, 10);
      bus(1'b0, 4'h0, 32'h0);
      check(rd, {16'h0, a & e & ~m});
    end
    bus(1'b1, 4'h8, 32'h0);
    bus(1'b1, 4'hc, 32'h0);
    bus(1'b1, 4'h4, 32'h3);
    pins(16'hffff, 3);
    pins(16'h0, 30);
    bus(1'b0, 4'h0, 32'h0);
    check(rd, 32'h0);
    pins(16'hffff, 40);
    bus(1'b0, 4'h0, 32'h0);
    check(rd, 32'hffffffff);
    give_verdict();
  end
endmodule
